//--- shared/swesc_regs.vh
`ifndef SWESC_REGS_VH
`define SWESC_REGS_VH

// ROM level command codes
`define SWESC_CMD_READ_ROM   8'h33
`define SWESC_CMD_MATCH_ROM  8'h55
`define SWESC_CMD_SEARCH_ROM 8'hf0
`define SWESC_CMD_SKIP_ROM   8'hcc
`define SWESC_CMD_HS_SKIP    8'h3c
`define SWESC_CMD_HS_MATCH   8'h69

// Memory function command codes
`define SWESC_CMD_WRITE_SP   8'h0f
`define SWESC_CMD_READ_SP    8'haa
`define SWESC_CMD_COPY_SP    8'h55
`define SWESC_CMD_READ_MEM   8'hf0

// Ending offset/status field positions
`define SWESC_ES_COPY_BIT    7
`define SWESC_ES_ZERO_BIT    6
`define SWESC_ES_PART_BIT    5

// Reset values
`define SWESC_TA_RESET       8'h00
`define SWESC_END_RESET      5'h00
`define SWESC_PART_RESET     1'b1

// Polynomials, reflected for LSB-first shifting
`define SWESC_CRC8_POLY      8'h8c
`define SWESC_CRC16_POLY     16'ha001

// Data patterns and limits
`define SWESC_FILL_BYTE      8'hff
`define SWESC_ALT_BYTE       8'haa
`define SWESC_SP_LAST        5'h1f
`define SWESC_ID_LAST_BIT    6'h37

// Timing
`define SWESC_CLK_PERIOD_NS  10
`define SWESC_COPY_TIME_NS   5000000

`endif

//--- rtl/swesc_crc8.v
`timescale 1ns/10ps
`include "swesc_regs.vh"
module swesc_crc8 (
	input  wire       mclk,
	input  wire       srst,
	input  wire       shift_en,
	input  wire       bit_in,
	output reg  [7:0] crc
);

	wire feedback;

	// Incoming bit mixed with the register's low bit
	assign feedback = bit_in ^ crc[0];

	// One shift per bit; starts cleared
	always @(posedge mclk) begin
		if (srst) begin
			crc <= 8'h00;
		end else if (shift_en) begin
			crc <= (crc >> 1) ^ (feedback ? `SWESC_CRC8_POLY : 8'h00);
		end
	end

endmodule

//--- rtl/swesc_ctrl.v
`timescale 1ns/10ps
`include "swesc_regs.vh"
module swesc_ctrl #(
	parameter [7:0]  FAMILY_CODE = 8'h5a,            // Arbitrary value
	parameter [47:0] SERIAL_NUM  = 48'h0000_0000_0001, // Arbitrary value
	parameter        COPY_CYCLES =
		`SWESC_COPY_TIME_NS / `SWESC_CLK_PERIOD_NS
) (
	input  wire       mclk,
	input  wire       srst,
	input  wire       line_reset,
	input  wire       reset_regular,
	input  wire       power_lost,
	input  wire       slot_pulse,
	input  wire       slot_read,
	input  wire       slot_wbit,
	output wire       tx_bit,
	output wire       tx_busy,
	output reg        speed_select,
	output reg  [7:0] target_addr_low,
	output reg  [7:0] target_addr_high,
	output wire [7:0] ending_offset_status
);

	localparam [3:0] S_INIT   = 4'h0;
	localparam [3:0] S_ROM    = 4'h1;
	localparam [3:0] S_MATCH  = 4'h2;
	localparam [3:0] S_ROMTX  = 4'h3;
	localparam [3:0] S_MEMCMD = 4'h4;
	localparam [3:0] S_TA1    = 4'h5;
	localparam [3:0] S_TA2    = 4'h6;
	localparam [3:0] S_WDATA  = 4'h7;
	localparam [3:0] S_WCRC   = 4'h8;
	localparam [3:0] S_RDSP   = 4'h9;
	localparam [3:0] S_RDMEM  = 4'ha;
	localparam [3:0] S_AUTH   = 4'hb;
	localparam [3:0] S_COPY   = 4'hc;
	localparam [3:0] S_DONE   = 4'hd;
	localparam [3:0] S_HALT   = 4'he;

	reg  [3:0]  state;
	reg  [3:0]  idx;
	reg  [5:0]  init_cnt;
	reg  [5:0]  ptr;
	reg  [9:0]  maddr;
	reg  [15:0] crc16;
	reg         is_write;
	reg         auth_ok;
	reg  [4:0]  end_off;
	reg         partial_flag;
	reg         copy_accepted_flag;
	reg  [4:0]  cp_idx;
	reg         cp_run;
	reg  [31:0] cp_wait;
	reg  [7:0]  rx_sh;
	reg  [2:0]  rx_cnt;
	reg         rx_done;
	reg  [7:0]  fq [0:1];
	reg         fq_head;
	reg  [1:0]  fq_cnt;
	reg  [7:0]  ser_sh;
	reg  [3:0]  ser_left;
	reg         push_valid;
	reg  [7:0]  push_data;
	reg  [7:0]  auth_exp;
	reg  [7:0]  scratch [0:31];
	reg  [7:0]  mem [0:511];
	wire [7:0]  rom_crc;
	wire [55:0] id56;
	wire [63:0] rom_id;
	wire        fq_in_ready;
	wire        fq_out_valid;
	wire        push;
	wire        pop;

	// Identity: type code in the low byte, CRC on top
	assign id56   = {SERIAL_NUM, FAMILY_CODE};
	assign rom_id = {rom_crc, id56};

	// Status byte; bit 6 hard zero, no write path exists
	assign ending_offset_status = {copy_accepted_flag, 1'b0,
		partial_flag, end_off};

	// Identity CRC is worked out bit by bit after reset
	swesc_crc8 u_crc8 (
		.mclk     (mclk),
		.srst     (srst),
		.shift_en (state == S_INIT),
		.bit_in   (id56[init_cnt]),
		.crc      (rom_crc)
	);

	// Byte-wise CRC16 over command, address and data
	function [15:0] crc16_byte;
		input [15:0] c;
		input [7:0]  d;
		integer      i;
		reg   [15:0] r;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (r[0] ^ d[i])
					r = (r >> 1) ^ `SWESC_CRC16_POLY;
				else
					r = r >> 1;
			end
			crc16_byte = r;
		end
	endfunction

	// Receiver: write slots shift in from the top, LSB first
	always @(posedge mclk) begin
		if (srst || line_reset) begin
			rx_sh   <= 8'h00;
			rx_cnt  <= 3'h0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (slot_pulse && !slot_read) begin
				rx_sh   <= {slot_wbit, rx_sh[7:1]};
				rx_cnt  <= rx_cnt + 3'h1;
				rx_done <= (rx_cnt == 3'h7);
			end
		end
	end

	// Two-entry buffer between byte source and serializer
	assign fq_in_ready  = (fq_cnt != 2'h2);
	assign fq_out_valid = (fq_cnt != 2'h0);
	assign push         = push_valid && fq_in_ready;
	assign pop          = fq_out_valid && (ser_left == 4'h0);

	always @(posedge mclk) begin
		if (srst || line_reset) begin
			fq_head <= 1'b0;
			fq_cnt  <= 2'h0;
		end else begin
			if (push)
				fq[fq_head ^ fq_cnt[0]] <= push_data;
			fq_head <= fq_head ^ pop;
			fq_cnt  <= fq_cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	// Serializer: idles at ones so an unloaded read slot reads 1
	always @(posedge mclk) begin
		if (srst || line_reset) begin
			ser_sh   <= 8'hff;
			ser_left <= 4'h0;
		end else if (pop) begin
			ser_sh   <= fq[fq_head];
			ser_left <= 4'h8;
		end else if (slot_pulse && slot_read && ser_left != 4'h0) begin
			ser_sh   <= {1'b1, ser_sh[7:1]};
			ser_left <= ser_left - 4'h1;
		end
	end

	assign tx_bit  = ser_sh[0];
	assign tx_busy = (ser_left != 4'h0);

	// Byte offered to the buffer in each sending state
	always @* begin
		push_valid = 1'b0;
		push_data  = `SWESC_FILL_BYTE;
		case (state)
			S_ROMTX: begin
				push_valid = 1'b1;
				push_data  = rom_id[{idx[2:0], 3'b000} +: 8];
			end
			S_WCRC: begin
				push_valid = 1'b1;
				push_data  = idx[0] ? ~crc16[15:8] : ~crc16[7:0];
			end
			S_RDSP: begin
				push_valid = 1'b1;
				if (idx == 4'h0)
					push_data = target_addr_low;
				else if (idx == 4'h1)
					push_data = target_addr_high;
				else if (idx == 4'h2)
					push_data = ending_offset_status;
				else if (!ptr[5])
					push_data = scratch[ptr[4:0]];
				else
					push_data = `SWESC_FILL_BYTE;
			end
			S_RDMEM: begin
				push_valid = 1'b1;
				if (!maddr[9])
					push_data = mem[maddr[8:0]];
			end
			S_DONE: begin
				push_valid = 1'b1;
				push_data  = `SWESC_ALT_BYTE;
			end
			default: begin
				push_valid = 1'b0;
			end
		endcase
	end

	// Expected authorization byte for the copy command
	always @* begin
		case (idx)
			4'h0:    auth_exp = target_addr_low;
			4'h1:    auth_exp = target_addr_high;
			default: auth_exp = ending_offset_status;
		endcase
	end

	// Command sequencer; the copy itself runs on below it so a
	// bus reset mid-copy does not leave a half-written page
	always @(posedge mclk) begin
		if (srst) begin
			state              <= S_INIT;
			idx                <= 4'h0;
			init_cnt           <= 6'h00;
			ptr                <= 6'h00;
			maddr              <= 10'h000;
			crc16              <= 16'h0000;
			is_write           <= 1'b0;
			auth_ok            <= 1'b0;
			target_addr_low    <= `SWESC_TA_RESET;
			target_addr_high   <= `SWESC_TA_RESET;
			end_off            <= `SWESC_END_RESET;
			partial_flag       <= `SWESC_PART_RESET;
			copy_accepted_flag <= 1'b0;
			speed_select       <= 1'b0;
			cp_idx             <= 5'h00;
			cp_run             <= 1'b0;
			cp_wait            <= 32'h0;
		end else begin
			if (line_reset && state != S_INIT) begin
				state <= S_ROM;
				idx   <= 4'h0;
				// A trailing fragment of a byte marks the write partial
				if (state == S_WDATA && rx_cnt != 3'h0)
					partial_flag <= 1'b1;
				if (reset_regular)
					speed_select <= 1'b0;
			end else begin
				case (state)
					S_INIT: begin
						init_cnt <= init_cnt + 6'h01;
						if (init_cnt == `SWESC_ID_LAST_BIT)
							state <= S_ROM;
					end
					S_ROM: if (rx_done) begin
						idx <= 4'h0;
						case (rx_sh)
							`SWESC_CMD_READ_ROM:  state <= S_ROMTX;
							`SWESC_CMD_MATCH_ROM: state <= S_MATCH;
							`SWESC_CMD_SKIP_ROM:  state <= S_MEMCMD;
							`SWESC_CMD_HS_SKIP: begin
								state        <= S_MEMCMD;
								speed_select <= 1'b1;
							end
							`SWESC_CMD_HS_MATCH: begin
								state        <= S_MATCH;
								speed_select <= 1'b1;
							end
							default: state <= S_HALT; // Search not served
						endcase
					end
					S_MATCH: if (rx_done) begin
						if (rx_sh != rom_id[{idx[2:0], 3'b000} +: 8])
							state <= S_HALT;
						else if (idx == 4'h7)
							state <= S_MEMCMD;
						else
							idx <= idx + 4'h1;
					end
					S_ROMTX: if (push) begin
						if (idx == 4'h7)
							state <= S_MEMCMD;
						else
							idx <= idx + 4'h1;
					end
					S_MEMCMD: if (rx_done) begin
						idx <= 4'h0;
						case (rx_sh)
							`SWESC_CMD_WRITE_SP: begin
								copy_accepted_flag <= 1'b0;
								crc16    <= crc16_byte(16'h0000, rx_sh);
								is_write <= 1'b1;
								state    <= S_TA1;
							end
							`SWESC_CMD_READ_MEM: begin
								is_write <= 1'b0;
								state    <= S_TA1;
							end
							`SWESC_CMD_READ_SP: begin
								ptr   <= {1'b0, target_addr_low[4:0]};
								state <= S_RDSP;
							end
							`SWESC_CMD_COPY_SP: begin
								auth_ok <= 1'b1;
								state   <= S_AUTH;
							end
							default: state <= S_HALT;
						endcase
					end
					S_TA1: if (rx_done) begin
						target_addr_low <= rx_sh;
						crc16 <= crc16_byte(crc16, rx_sh);
						state <= S_TA2;
					end
					S_TA2: if (rx_done) begin
						// Only bit 8 of the address survives
						target_addr_high <= {7'h00, rx_sh[0]};
						crc16 <= crc16_byte(crc16, rx_sh);
						if (is_write) begin
							ptr   <= {1'b0, target_addr_low[4:0]};
							state <= S_WDATA;
						end else begin
							maddr <= {1'b0, rx_sh[0], target_addr_low};
							state <= S_RDMEM;
						end
					end
					S_WDATA: if (rx_done) begin
						scratch[ptr[4:0]] <= rx_sh;
						end_off      <= ptr[4:0];
						partial_flag <= 1'b0;
						crc16        <= crc16_byte(crc16, rx_sh);
						ptr          <= ptr + 6'h01;
						// Last offset filled: further bytes are not kept
						if (ptr[4:0] == `SWESC_SP_LAST)
							state <= S_WCRC;
					end
					S_WCRC: if (push) begin
						if (idx == 4'h1)
							state <= S_HALT;
						else
							idx <= idx + 4'h1;
					end
					S_RDSP: if (push) begin
						if (idx < 4'h3)
							idx <= idx + 4'h1;
						else if (!ptr[5])
							ptr <= ptr + 6'h01;
					end
					S_RDMEM: if (push && !maddr[9])
						maddr <= maddr + 10'h001;
					S_AUTH: if (rx_done) begin
						if (rx_sh != auth_exp)
							auth_ok <= 1'b0;
						idx <= idx + 4'h1;
						if (idx == 4'h2) begin
							if (auth_ok && rx_sh == auth_exp && !partial_flag) begin
								copy_accepted_flag <= 1'b1;
								cp_idx  <= target_addr_low[4:0];
								cp_run  <= 1'b1;
								cp_wait <= 32'h0;
								state   <= S_COPY;
							end else begin
								state <= S_HALT;
							end
						end
					end
					S_COPY: begin
						// Bus stays quiet for the whole programming time
						cp_wait <= cp_wait + 32'h1;
						if (cp_wait == COPY_CYCLES - 1)
							state <= S_DONE;
					end
					S_DONE: state <= S_DONE;
					S_HALT: state <= S_HALT;
					default: state <= S_HALT;
				endcase
			end
			// Page copy, one byte a cycle, start offset to end offset
			if (cp_run) begin
				mem[{target_addr_high[0], target_addr_low[7:5], cp_idx}]
					<= scratch[cp_idx];
				if (cp_idx == end_off)
					cp_run <= 1'b0;
				else
					cp_idx <= cp_idx + 5'h01;
			end
			// Power loss outranks a same-cycle clear
			if (power_lost)
				partial_flag <= 1'b1;
		end
	end

endmodule

//--- test/swesc_ctrl_properties.sv
`timescale 1ns/10ps
module swesc_props (
	input wire       mclk,
	input wire       srst,
	input wire       line_reset,
	input wire       reset_regular,
	input wire       power_lost,
	input wire       slot_pulse,
	input wire       slot_read,
	input wire       tx_bit,
	input wire       tx_busy,
	input wire       speed_select,
	input wire [7:0] target_addr_low,
	input wire [7:0] target_addr_high,
	input wire [7:0] ending_offset_status
);
	// Events that may move the speed, kept to look back on
	wire wslot = slot_pulse & ~slot_read;
	wire slow  = srst | (line_reset & reset_regular);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	zero_bit_a: assert property (!ending_offset_status[6])
		else $error("status bit 6 set");
	addr_top_a: assert property (
		target_addr_high[7:1] == 7'h00)
		else $error("address top bits set");
	reset_values_a: assert property (disable iff (1'b0)
		srst |=> !speed_select && tx_bit && !tx_busy
		&& {target_addr_low, ending_offset_status} == 16'h0020)
		else $error("reset values wrong");
	power_partial_a: assert property (
		power_lost |=> ending_offset_status[5])
		else $error("power loss not flagged");
	speed_rise_a: assert property (
		$rose(speed_select) |->
		$past(wslot) || $past(wslot, 2) || $past(wslot, 3))
		else $error("speed rose without a command byte");
	speed_fall_a: assert property (
		$fell(speed_select) |-> $past(slow) || $past(slow, 2))
		else $error("speed fell without regular reset");
	speed_clear_a: assert property (
		line_reset && reset_regular |-> ##[1:2] !speed_select)
		else $error("regular reset kept high speed");
	flush_tx_a: assert property (
		line_reset |=> !tx_busy && tx_bit)
		else $error("bus reset left sender busy");
	// Main paths: speed up, copy accepted, byte sent
	cover property ($rose(speed_select));
	cover property ($rose(ending_offset_status[7]));
	cover property ($rose(tx_busy));
endmodule

bind swesc_ctrl swesc_props i_props (
	.mclk                 (mclk),
	.srst                 (srst),
	.line_reset           (line_reset),
	.reset_regular        (reset_regular),
	.power_lost           (power_lost),
	.slot_pulse           (slot_pulse),
	.slot_read            (slot_read),
	.tx_bit               (tx_bit),
	.tx_busy              (tx_busy),
	.speed_select         (speed_select),
	.target_addr_low      (target_addr_low),
	.target_addr_high     (target_addr_high),
	.ending_offset_status (ending_offset_status)
);

//--- test/swesc_master.sv
`timescale 1ns/10ps
module swesc_master (
	input  wire mclk,
	input  wire tx_bit,
	output reg  line_reset    = 1'b0,
	output reg  reset_regular = 1'b0,
	output reg  slot_pulse    = 1'b0,
	output reg  slot_read     = 1'b0,
	output reg  slot_wbit     = 1'b0
);
	// Bus reset; only a regular one drops high speed
	task bus_reset(input reg reg_len);
		begin
			@(posedge mclk);
			line_reset <= 1'b1;
			reset_regular <= reg_len;
			@(posedge mclk);
			line_reset <= 1'b0;
			reset_regular <= ~reg_len;
			repeat (3) @(posedge mclk);
		end
	endtask
	// One slot; released qualifiers flip so a stale level never helps
	task slot(input reg rd, input reg wb, output reg rb);
		begin
			@(posedge mclk);
			rb = tx_bit;
			slot_pulse <= 1'b1;
			slot_read <= rd;
			slot_wbit <= wb;
			@(posedge mclk);
			slot_pulse <= 1'b0;
			slot_read <= ~rd;
			slot_wbit <= ~wb;
			repeat (3) @(posedge mclk);
		end
	endtask
	// Whole bytes, least significant bit first
	task wbyte(input reg [7:0] v);
		integer k;
		reg     x;
		begin
			for (k = 0; k < 8; k = k + 1)
				slot(1'b0, v[k], x);
		end
	endtask
	task rbyte(output reg [7:0] v);
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1)
				// Written bit of a read slot varies; the device must ignore it
				slot(1'b1, k[0], v[k]);
		end
	endtask
endmodule

//--- test/swesc_ctrl_tb.sv
`timescale 1ns/10ps
`include "swesc_regs.vh"
module swesc_ctrl_tb;
	localparam [7:0]  FAM = 8'h3e;              // Arbitrary value
	localparam [47:0] SER = 48'h0a1b_2c3d_4e5f; // Arbitrary value
	reg         mclk = 1'b0;
	reg         srst = 1'b1;
	reg         power_lost = 1'b0;
	wire        line_reset, reset_regular, slot_pulse, slot_read, slot_wbit;
	wire        tx_bit, tx_busy, speed_select;
	wire [7:0]  target_addr_low, target_addr_high, ending_offset_status;
	integer     n_mismatch = 0, n_checks = 0, seed = 75, i;
	reg  [7:0]  sp [0:31];
	reg  [7:0]  q [$];
	reg  [7:0]  b, e_lo, e_hi, e_es;
	reg  [15:0] crc;
	reg  [63:0] rom;

	always #5 mclk = ~mclk;

	// Short copy wait keeps the run brief
	swesc_ctrl #(
		.FAMILY_CODE (FAM),
		.SERIAL_NUM  (SER),
		.COPY_CYCLES (20)
	) i_dut (
		.mclk                 (mclk),
		.srst                 (srst),
		.line_reset           (line_reset),
		.reset_regular        (reset_regular),
		.power_lost           (power_lost),
		.slot_pulse           (slot_pulse),
		.slot_read            (slot_read),
		.slot_wbit            (slot_wbit),
		.tx_bit               (tx_bit),
		.tx_busy              (tx_busy),
		.speed_select         (speed_select),
		.target_addr_low      (target_addr_low),
		.target_addr_high     (target_addr_high),
		.ending_offset_status (ending_offset_status)
	);
	swesc_master i_m (
		.mclk          (mclk),
		.tx_bit        (tx_bit),
		.line_reset    (line_reset),
		.reset_regular (reset_regular),
		.slot_pulse    (slot_pulse),
		.slot_read     (slot_read),
		.slot_wbit     (slot_wbit)
	);

	function [15:0] crc16(input [15:0] c, input [7:0] d);
		integer k;
		begin
			crc16 = c;
			for (k = 0; k < 8; k = k + 1)
				crc16 = (crc16 >> 1) ^ ((crc16[0] ^ d[k]) ? 16'ha001 : 16'h0);
		end
	endfunction
	function [7:0] crc8(input [63:0] v, input integer n);
		integer k;
		begin
			crc8 = 8'h00;
			for (k = 0; k < n; k = k + 1)
				crc8 = (crc8 >> 1) ^ ((crc8[0] ^ v[k]) ? 8'h8c : 8'h00);
		end
	endfunction
	task check(input [63:0] seen, input [63:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_mismatch);
			if (n_mismatch == 0 && n_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// Regular reset, skip the identity step, then a memory command
	task sel(input [7:0] cmd);
		begin
			i_m.bus_reset(1'b1);
			i_m.wbyte(`SWESC_CMD_SKIP_ROM);
			i_m.wbyte(cmd);
		end
	endtask
	task auth(input [7:0] x);
		begin
			i_m.wbyte(e_lo);
			i_m.wbyte(e_hi);
			i_m.wbyte(x);
		end
	endtask
	// Scratchpad write mirrored into the model
	task wr_sp(input [7:0] lo, input [7:0] hi, input integer n);
		integer k;
		reg [7:0] d;
		begin
			sel(8'h0f);
			i_m.wbyte(lo);
			i_m.wbyte(hi);
			crc = crc16(crc16(crc16(16'h0000, 8'h0f), lo), hi);
			for (k = 0; k < n; k = k + 1) begin
				d = $random(seed);
				sp[lo[4:0] + k] = d;
				crc = crc16(crc, d);
				i_m.wbyte(d);
			end
			e_lo = lo;
			e_hi = {7'h00, hi[0]};
			e_es = 8'(lo[4:0] + n - 1);
			if (e_es == 8'h1f) begin
				i_m.rbyte(b);
				i_m.rbyte(d);
				// Inverted as 16 bits, before widening to the compare
				check({d, b}, {48'h0, ~crc});
			end
			check(ending_offset_status, e_es);
			check({target_addr_high, target_addr_low}, {e_hi, e_lo});
		end
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		check({speed_select, target_addr_low}, 9'h000);
		check(ending_offset_status, 8'h20);
		srst <= 1'b0;
		repeat (60) @(posedge mclk);
		// Identity read back, its CRC re-run
		i_m.bus_reset(1'b1);
		i_m.wbyte(`SWESC_CMD_READ_ROM);
		for (i = 0; i < 64; i = i + 1)
			i_m.slot(1'b1, i[0], rom[i]);
		check(rom[55:0], {SER, FAM});
		check(rom[63:56], crc8(rom, 56));
		check(crc8(rom, 64), 8'h00);
		// A memory command before any identity command goes unanswered
		i_m.bus_reset(1'b1);
		i_m.wbyte(8'haa);
		i_m.rbyte(b);
		check(b, 8'hff);
		wr_sp(8'h3c, $random(seed), 4);
		q = {e_lo, e_hi, e_es, sp[28], sp[29], sp[30], sp[31], 8'hff};
		sel(8'haa);
		for (i = 0; i < 8; i = i + 1) begin
			i_m.rbyte(b);
			check(b, q[i]);
		end
		// Wrong pattern, then the right one
		sel(8'h55);
		auth(8'h1e);
		i_m.rbyte(b);
		check({b, ending_offset_status}, {8'hff, e_es});
		sel(8'h55);
		auth(e_es);
		repeat (60) @(posedge mclk);
		i_m.rbyte(b);
		check({b, ending_offset_status}, {8'haa, 8'h9f});
		sel(8'hf0);
		i_m.wbyte(e_lo);
		i_m.wbyte(e_hi);
		for (i = 28; i < 32; i = i + 1) begin
			i_m.rbyte(b);
			check(b, sp[i]);
		end
		// Fragment cut by a bus reset
		sel(8'h0f);
		i_m.wbyte(8'h3c);
		i_m.wbyte(8'h00);
		for (i = 0; i < 3; i = i + 1)
			i_m.slot(1'b0, i[0], b[0]);
		i_m.bus_reset(1'b1);
		check(ending_offset_status[7:5], 3'b001);
		// Readback shows the partial flag, so the master writes again
		sel(8'haa);
		for (i = 0; i < 3; i = i + 1)
			i_m.rbyte(b);
		check(b, {3'b001, e_es[4:0]});
		// Retry from a page start uses the whole scratchpad
		wr_sp(8'h40, $random(seed), 32);
		sel(8'haa);
		for (i = 0; i < 4; i = i + 1)
			i_m.rbyte(b);
		check(b, sp[0]);
		wr_sp(8'h3f, 8'h00, 1);
		@(posedge mclk) power_lost <= 1'b1;
		@(posedge mclk) power_lost <= 1'b0;
		@(posedge mclk);
		check(ending_offset_status, 8'h3f);
		// Speed changes and identity match
		i_m.bus_reset(1'b1);
		i_m.wbyte(`SWESC_CMD_HS_SKIP);
		repeat (4) @(posedge mclk);
		check(speed_select, 1'b1);
		i_m.bus_reset(1'b0);
		check(speed_select, 1'b1);
		i_m.wbyte(`SWESC_CMD_MATCH_ROM);
		for (i = 0; i < 64; i = i + 1)
			i_m.slot(1'b0, rom[i], b[0]);
		i_m.wbyte(8'haa);
		i_m.rbyte(b);
		check(b, e_lo);
		i_m.bus_reset(1'b1);
		check(speed_select, 1'b0);
		i_m.wbyte(`SWESC_CMD_HS_MATCH);
		for (i = 0; i < 64; i = i + 1)
			i_m.slot(1'b0, rom[i], b[0]);
		repeat (4) @(posedge mclk);
		check(speed_select, 1'b1);
		give_verdict;
	end

	// Hang guard, several times the expected run
	initial begin
		repeat (30000) @(posedge mclk);
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
endmodule
